// ==== stl_pkg.sv ====
/*
  Shared constants for the serial-to-parallel latch: widths, depths,
  reset values and synchroniser length.
  Assumes every user names constants as stl_pkg::name; nothing imports it.
*/
// Behaviour
// - eight-stage shift register, eight-bit storage latch, three-state parallel outputs.
// - each rising shift clock edge: stage zero takes input, others shift up.
// - latch gate high: storage follows shift register; low: storage holds.
// - output enable high drives storage out; low floats it, serial outputs continue.
// - early serial out takes seventh stage on rising edge, holds on falling.
// - late serial out takes last stage on falling edge, holds on rising.
package stl_pkg;

  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int unsigned STAGES      = 8;
  localparam int unsigned SYNC_FLOPS  = 3;
  localparam int unsigned FIFO_DEPTH  = 8;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  WORD_RST    = 8'h00;
  localparam logic        BIT_RST     = 1'h0;

endpackage : stl_pkg

// ==== stl_sync.sv ====
/*
  Three-flop pin synchroniser with agreement filter, one lane per bit.
  Assumes inputs are asynchronous to i_clk_sys; reset is synchronous.
*/
`timescale 1ns/10ps
module stl_sync #(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  // pins in, filtered levels out
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  // ----------------------------------------------------------------
  // per-bit chain
  // ----------------------------------------------------------------
  // the first flop feeds only the second; filter looks at 2nd and 3rd
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          s1_reg  <= stl_pkg::BIT_RST;
          s2_reg  <= stl_pkg::BIT_RST;
          s3_reg  <= stl_pkg::BIT_RST;
          lvl_reg <= stl_pkg::BIT_RST;
        end else begin
          s1_reg <= i_pin[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      assign o_level[g] = lvl_reg;
    end
  endgenerate

endmodule : stl_sync

// ==== stl_fifo.sv ====
/*
  Flip-flop FIFO with valid/ready on both sides and honest full/empty.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module stl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;

  wire logic push   = i_in_valid && o_in_ready;
  wire logic pop    = o_out_valid && i_out_ready;
  wire logic wr_end = (wr_reg == AW'(DEPTH - 1));
  wire logic rd_end = (rd_reg == AW'(DEPTH - 1));

  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rd_reg];

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_end ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_end ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule : stl_fifo

// ==== stl_top.sv ====
/*
  Serial-to-parallel latch: shift register, storage latch, gated
  parallel outputs, two cascade outputs, and a FIFO of latched words.
  Assumes the host pins are asynchronous and much slower than i_clk_sys;
  the shift clock is sampled, not used as a clock.
*/
`timescale 1ns/10ps
module stl_top #(
  parameter int unsigned WIDTH = stl_pkg::STAGES,
  parameter int unsigned DEPTH = stl_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  // host pins
  input  wire logic             i_shift_clock,
  input  wire logic             i_serial_in,
  input  wire logic             i_latch_gate,
  input  wire logic             i_output_enable,
  // parallel pins, three-state as value plus enable
  output logic      [WIDTH-1:0] o_parallel_out,
  output logic      [WIDTH-1:0] o_parallel_oe,
  // cascade pins
  output logic                  o_early_serial_out,
  output logic                  o_late_serial_out,
  // latched word stream
  output logic                  o_capture_ready,
  output logic                  o_word_valid,
  input  wire logic             i_word_ready,
  output logic      [WIDTH-1:0] o_word_data
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_lvl;

  stl_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_pin     ({i_output_enable, i_latch_gate, i_serial_in, i_shift_clock}),
    .o_level   (pin_lvl)
  );

  wire logic clk_lvl  = pin_lvl[0];
  wire logic din_lvl  = pin_lvl[1];
  wire logic gate_lvl = pin_lvl[2];
  wire logic oe_lvl   = pin_lvl[3];

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic clk_d_reg;
  logic gate_d_reg;

  wire logic clk_rise  = clk_lvl && !clk_d_reg;
  wire logic clk_fall  = !clk_lvl && clk_d_reg;
  wire logic gate_fall = !gate_lvl && gate_d_reg;

  // ----------------------------------------------------------------
  // shift register, storage, cascade outputs
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] store_reg;
  logic             early_reg;
  logic             late_reg;

  wire logic [WIDTH-1:0] shift_next = {shift_reg[WIDTH-2:0], din_lvl};

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      clk_d_reg  <= stl_pkg::BIT_RST;
      gate_d_reg <= stl_pkg::BIT_RST;
      shift_reg  <= WIDTH'(stl_pkg::WORD_RST);
      store_reg  <= WIDTH'(stl_pkg::WORD_RST);
      early_reg  <= stl_pkg::BIT_RST;
      late_reg   <= stl_pkg::BIT_RST;
    end else begin
      clk_d_reg  <= clk_lvl;
      gate_d_reg <= gate_lvl;
      if (clk_rise) begin
        shift_reg <= shift_next;
        early_reg <= shift_reg[WIDTH-2];
      end
      if (clk_fall) begin
        late_reg <= shift_reg[WIDTH-1];
      end
      // transparent while gate high; a rising edge seen with the gate
      // open lands in storage in the same cycle as in the shifter
      if (gate_lvl) begin
        store_reg <= clk_rise ? shift_next : shift_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_parallel_out     = store_reg;
  assign o_parallel_oe      = {WIDTH{oe_lvl}};
  assign o_early_serial_out = early_reg;
  assign o_late_serial_out  = late_reg;

  // ----------------------------------------------------------------
  // latched word capture
  // ----------------------------------------------------------------
  // one word per closing of the gate; a full FIFO drops it, so the
  // host watches o_capture_ready before ending a strobe
  stl_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (gate_fall),
    .o_in_ready  (o_capture_ready),
    .i_in_data   (store_reg),
    .o_out_valid (o_word_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (o_word_data)
  );

endmodule : stl_top

// ==== stl_monitor.sv ====
/* pin-level checker for the latch top.
   assumes host pin levels stand at least eight system cycles. */
`timescale 1ns/10ps
module stl_monitor #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic             i_clk_sys,
  input wire logic             i_sys_rst,
  // host pins and device outputs
  input wire logic             i_shift_clock,
  input wire logic             i_latch_gate,
  input wire logic             i_output_enable,
  input wire logic [WIDTH-1:0] o_parallel_out,
  input wire logic [WIDTH-1:0] o_parallel_oe,
  input wire logic             o_early_serial_out,
  input wire logic             o_late_serial_out
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  property p_oe_on; i_output_enable [*6] |=> &o_parallel_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
  property p_oe_off; !i_output_enable [*6] |=> o_parallel_oe == '0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs not floated");
  property p_split; $changed(o_early_serial_out) |-> $stable(o_late_serial_out); endproperty
  a_split: assert property (p_split) else $error("serial outs moved together");
  property p_early; $changed(o_early_serial_out) |-> $past(i_shift_clock, 2); endproperty
  a_early: assert property (p_early) else $error("early out moved off rise");
  property p_late; $changed(o_late_serial_out) |-> !$past(i_shift_clock, 2); endproperty
  a_late: assert property (p_late) else $error("late out moved off fall");
  property p_copy; $changed(o_late_serial_out) |-> o_late_serial_out == o_early_serial_out; endproperty
  a_copy: assert property (p_copy) else $error("late out not last stage");
  property p_hold; !i_latch_gate [*8] |=> $stable(o_parallel_out); endproperty
  a_hold: assert property (p_hold) else $error("storage moved while closed");
  property p_follow; (i_latch_gate && !i_shift_clock) [*8] |-> o_parallel_out[WIDTH-1] == o_early_serial_out;
  endproperty
  a_follow: assert property (p_follow) else $error("storage not following");
endmodule : stl_monitor

bind stl_top stl_monitor #(.WIDTH(WIDTH)) stl_monitor_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_shift_clock(i_shift_clock), .i_latch_gate(i_latch_gate), .i_output_enable(i_output_enable),
  .o_parallel_out(o_parallel_out), .o_parallel_oe(o_parallel_oe),
  .o_early_serial_out(o_early_serial_out), .o_late_serial_out(o_late_serial_out));

// ==== stl_host.sv ====
/* host model driving the serial pins of one device.
   assumes its caller resumes on a rising system clock edge. */
`timescale 1ns/10ps
module stl_host (
  input  wire logic i_clk_sys,
  output logic      o_shift_clock = 1'h0,
  output logic      o_serial_in   = 1'h0,
  output logic      o_latch_gate  = 1'h0
);
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : hold
  // data set up eight cycles ahead, then a rising shift clock
  task automatic rise(input logic value);
    o_serial_in <= value;
    hold(8);
    o_shift_clock <= 1'h1;
    hold(8);
  endtask : rise
  // falling shift clock closes the bit
  task automatic fall();
    o_shift_clock <= 1'h0;
    hold(8);
  endtask : fall
  // msb first, gate low while shifting; data flips after hold
  task automatic send(input logic [7:0] word);
    for (int i = 7; i >= 0; i--) begin
      rise(word[i]);
      fall();
    end
    o_serial_in <= ~word[0];
  endtask : send
  // gate level held open or closed for eight cycles
  task automatic gate_to(input logic level);
    o_latch_gate <= level;
    hold(8);
  endtask : gate_to
  // gate pulse copies stages to storage
  task automatic strobe();
    o_latch_gate <= 1'h1;
    hold(8);
    o_latch_gate <= 1'h0;
    hold(10);
  endtask : strobe
endmodule : stl_host

// ==== stl_tb_top.sv ====
/* self-checking bench for the latch top.
   assumes the host model and the bound checker sit beside it. */
`timescale 1ns/10ps
module stl_tb_top;
  logic       clk, rst, oe, rdy, sclk, sdat, gate, early, late, cready, wvalid;
  logic [7:0] pout, poe, wdata;
  int         n_errors = 0;
  int         samples_checked = 0;
  stl_host stl_host_i (.i_clk_sys(clk), .o_shift_clock(sclk), .o_serial_in(sdat), .o_latch_gate(gate));
  stl_top stl_top_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_shift_clock(sclk), .i_serial_in(sdat),
    .i_latch_gate(gate), .i_output_enable(oe), .o_parallel_out(pout), .o_parallel_oe(poe),
    .o_early_serial_out(early), .o_late_serial_out(late), .o_capture_ready(cready),
    .o_word_valid(wvalid), .i_word_ready(rdy), .o_word_data(wdata));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic pop(input logic [7:0] exp);
    @(negedge clk);
    chk("valid", 8'h01, {7'h00, wvalid});
    chk("word", exp, wdata);
    @(posedge clk);
    rdy <= 1'h1;
    @(posedge clk);
    rdy <= 1'h0;
  endtask : pop
  task automatic t_clear();
    chk("reset word", 8'h00, pout);
    chk("reset ready", 8'h01, {7'h00, cready});
    chk("reset valid", 8'h00, {7'h00, wvalid});
    chk("reset early", 8'h00, {7'h00, early});
    chk("reset late", 8'h00, {7'h00, late});
    stl_host_i.send(8'h00);
    stl_host_i.strobe();
    pop(8'h00);
  endtask : t_clear
  task automatic t_load();
    stl_host_i.send(8'hA5);
    chk("held", 8'h00, pout);
    chk("early", 8'h01, {7'h00, early});
    chk("late", 8'h01, {7'h00, late});
    stl_host_i.strobe();
    chk("parallel", 8'hA5, pout);
    chk("drive", 8'hFF, poe);
    pop(8'hA5);
  endtask : t_load
  task automatic t_oe();
    oe <= 1'h0;
    stl_host_i.send(8'h3C);
    chk("float", 8'h00, poe);
    chk("closed", 8'hA5, pout);
    chk("early", 8'h00, {7'h00, early});
    chk("late", 8'h00, {7'h00, late});
    oe <= 1'h1;
    stl_host_i.strobe();
    chk("drive", 8'hFF, poe);
    chk("parallel", 8'h3C, pout);
    pop(8'h3C);
  endtask : t_oe
  task automatic t_fifo();
    for (int i = 0; i < 9; i++) begin
      stl_host_i.send(8'(8'h11 * i));
      stl_host_i.strobe();
    end
    chk("full", 8'h00, {7'h00, cready});
    for (int i = 0; i < 8; i++) pop(8'(8'h11 * i));
    @(negedge clk);
    chk("empty", 8'h00, {7'h00, wvalid});
    @(posedge clk);
  endtask : t_fifo
  task automatic t_cascade();
    logic [7:0] model = 8'hC3;
    logic [7:0] nxt = 8'h5A;
    logic       prev;
    stl_host_i.send(model);
    stl_host_i.gate_to(1'h1);
    for (int i = 7; i >= 0; i--) begin
      prev = model[7];
      model = {model[6:0], nxt[i]};
      stl_host_i.rise(nxt[i]);
      chk("early", {7'h00, model[7]}, {7'h00, early});
      chk("late hold", {7'h00, prev}, {7'h00, late});
      chk("follow", model, pout);
      stl_host_i.fall();
      chk("late", {7'h00, model[7]}, {7'h00, late});
      chk("early hold", {7'h00, model[7]}, {7'h00, early});
    end
    stl_host_i.gate_to(1'h0);
    pop(nxt);
  endtask : t_cascade
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    rst = 1'h1;
    oe = 1'h1;
    rdy = 1'h0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    t_clear();
    t_load();
    t_oe();
    t_fifo();
    t_cascade();
    conclude();
  end
  initial begin
    repeat (10000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : stl_tb_top
